// >>> i2c_control_enable_wait.sv
// Purpose: control register slice of a multimaster two-wire controller
// Assumes: single clock, synchronous reset, flag set pulses from the data path
// Notes:   pins are open drain, so only output enables are driven
// How it works
// - reset clears whole control register
// - control bits enable down to stop trigger
// - byte writes and single-bit writes both accepted
// - option bits taken alongside enable rising
// - enable low stops logic, status held reset
// - disabling clears fail, busy, level detect bits
// - commands ignored while disabled
// - exit command releases lines, standby, self-clears
// - exit clears triggers and status flags except stop detect
// - standby until stop, or match or extension code after a start
// - wait cancel releases clock, self-clears
// - ninth-clock cancel while sending clears direction
// - command bits always read zero
// - enable with data low and filter on gives start detect
// - wait and interrupt at eighth or ninth edge
// - ack drives data low in ninth clock
// - stop raises interrupt when enabled
`timescale 1ns/1ps
module i2c_control_enable_wait (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_bit_wr,
	input  wire logic [2:0]  reg_bit_idx,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        serial_clock_line,
	input  wire logic        serial_data_line,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        digital_filter_on,
	input  wire logic        master_set,
	input  wire logic        extension_code_set,
	input  wire logic        address_match_set,
	input  wire logic        transmit_dir_set,
	input  wire logic        ack_detected_set,
	input  wire logic        start_fail_set,
	output logic             irq,
	output logic             start_trigger,
	output logic             stop_trigger,
	output logic [7:0]       status_reg
);
	import i2c_ctl_pkg::*;

	// whole state of the slice
	typedef struct packed {
		logic       enable;
		logic       spie;
		logic       wtim;
		logic       acke;
		logic       stt;
		logic       spt;
		logic [7:0] status;
		logic       start_fail;
		logic       busy;
		logic       cld;
		logic       dad;
		phase_t     phase;
		logic [3:0] bit_cnt;   // falling clock edges in this byte
		logic       wait_ninth; // present wait sits on the ninth edge
		logic       scl_q;     // previous filtered clock level
		logic       sda_q;     // previous filtered data level
		logic       scl_oe;
		logic       sda_oe;
		logic       irq;
		logic [7:0] rdata;
	} state_t;

	state_t     st;      // registered state
	state_t     next_st; // next state
	logic [1:0] lines_s; // filtered {clock, data}
	logic       scl_s;
	logic       sda_s;
	logic       ctl_hit;  // access targets the control register
	logic       wr_any;   // byte or bit write to control
	logic [7:0] wr_val;   // effective written byte
	logic [7:0] wr_mask;  // bits touched by this write
	logic       exit_cmd; // exit command accepted this cycle
	logic       wrel_cmd; // wait cancel accepted this cycle
	logic       start_ev;
	logic       stop_ev;
	logic       fall_ev;

	// edge helpers on filtered line levels
	function automatic logic rose(input logic prev, input logic now);
		return !prev && now;
	endfunction

	function automatic logic fell(input logic prev, input logic now);
		return prev && !now;
	endfunction

	// control register as software reads it, commands always zero
	function automatic logic [7:0] ctl_view(input state_t s);
		logic [7:0] v;
		v = CTL_RESET;
		v[B_ENABLE] = s.enable;
		v[B_SPIE]   = s.spie;
		v[B_WTIM]   = s.wtim;
		v[B_ACKE]   = s.acke;
		v[B_STT]    = s.stt;
		v[B_SPT]    = s.spt;
		return v;
	endfunction

	// pins come from another domain
	line_sync3 #(.WIDTH(2)) u_sync (
		.clock (clock),
		.srst  (srst),
		.din   ({serial_clock_line, serial_data_line}),
		.dout  (lines_s)
	);
	assign scl_s = lines_s[1];
	assign sda_s = lines_s[0];

	// write decode: bit writes change only the addressed bit
	always_comb begin
		ctl_hit = (reg_addr == ADDR_CTL_MAIN);
		wr_any  = ctl_hit && (reg_wr || reg_bit_wr);
		wr_mask = reg_bit_wr ? (8'h01 << reg_bit_idx) : 8'hFF;
		wr_val  = reg_bit_wr ? ((ctl_view(st) & ~wr_mask) | ({8{reg_wdata[0]}} & wr_mask))
		                     : reg_wdata;
		// commands act only when already enabled
		exit_cmd = wr_any && st.enable && wr_mask[B_EXIT] && wr_val[B_EXIT];
		wrel_cmd = wr_any && st.enable && wr_mask[B_WREL] && wr_val[B_WREL];
		start_ev = st.enable && st.scl_q && scl_s && st.sda_q && !sda_s;
		stop_ev  = st.enable && st.scl_q && scl_s && rose(st.sda_q, sda_s);
		fall_ev  = st.enable && fell(st.scl_q, scl_s);
	end

	// next state
	always_comb begin
		next_st = st;
		next_st.irq   = 1'b0;
		next_st.scl_q = scl_s;
		next_st.sda_q = sda_s;
		// read data stand in the following cycle only
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_CTL_MAIN: next_st.rdata = ctl_view(st);
				ADDR_STATUS:   next_st.rdata = st.status;
				ADDR_FLAGS:    next_st.rdata = {st.start_fail, st.busy, 6'h00};
				ADDR_CLK_SEL:  next_st.rdata = {2'h0, st.cld, st.dad, 4'h0};
				default:       next_st.rdata = 8'h00;
			endcase
		end
		// control bits; option bits accepted in any access, including enable rise
		if (wr_any) begin
			if (wr_mask[B_ENABLE]) next_st.enable = wr_val[B_ENABLE];
			if (wr_mask[B_SPIE])   next_st.spie   = wr_val[B_SPIE];
			if (wr_mask[B_WTIM])   next_st.wtim   = wr_val[B_WTIM];
			if (wr_mask[B_ACKE])   next_st.acke   = wr_val[B_ACKE];
			if (wr_mask[B_STT])    next_st.stt    = wr_val[B_STT];
			if (wr_mask[B_SPT])    next_st.spt    = wr_val[B_SPT];
		end
		if (st.enable) begin
			next_st.cld = scl_s;
			next_st.dad = sda_s;
			// start condition seen on the bus
			if (start_ev) begin
				next_st.status[S_STD] = 1'b1;
				next_st.status[S_SPD] = 1'b0;
				next_st.busy    = 1'b1;
				// the clock fall that closes the start is no data clock: it wraps this to zero
				next_st.bit_cnt = 4'hF;
				if (st.phase != PH_STANDBY) next_st.phase = PH_XFER;
			end
			// stop condition frees the bus and ends standby
			if (stop_ev) begin
				next_st.status = 8'h00;
				next_st.status[S_SPD] = 1'b1;
				next_st.busy   = 1'b0;
				next_st.phase  = PH_IDLE;
				next_st.scl_oe = 1'b0;
				next_st.sda_oe = 1'b0;
				next_st.irq    = st.spie;
			end
			// counting clock edges, wait point by timing select
			if (fall_ev && st.phase == PH_XFER) begin
				next_st.bit_cnt = st.bit_cnt + 4'h1;
				if (st.bit_cnt + 4'h1 == WAIT_EARLY) begin
					next_st.sda_oe = st.acke && !st.status[S_TRC];
					if (!st.wtim) begin
						next_st.phase      = PH_WAIT;
						next_st.scl_oe     = 1'b1;
						next_st.irq        = 1'b1;
						next_st.wait_ninth = 1'b0;
					end
				end else if (st.bit_cnt + 4'h1 == WAIT_LATE) begin
					next_st.bit_cnt = 4'h0;
					next_st.sda_oe  = 1'b0; // ack period over
					if (st.wtim) begin
						next_st.phase      = PH_WAIT;
						next_st.scl_oe     = 1'b1;
						next_st.irq        = 1'b1;
						next_st.wait_ninth = 1'b1;
					end
				end
			end
			// wait cancel; outside a wait the command simply vanishes
			if (wrel_cmd && st.phase == PH_WAIT) begin
				next_st.phase  = PH_XFER;
				next_st.scl_oe = 1'b0;
				if (st.wait_ninth && st.status[S_TRC]) begin
					next_st.status[S_TRC] = 1'b0;
					next_st.sda_oe = 1'b0;
				end
			end
			// exit from communication wins over the bus events above
			if (exit_cmd) begin
				next_st.phase  = PH_STANDBY;
				next_st.scl_oe = 1'b0;
				next_st.sda_oe = 1'b0;
				next_st.stt    = 1'b0;
				next_st.spt    = 1'b0;
				next_st.status[S_MASTER] = 1'b0;
				next_st.status[S_EXC]    = 1'b0;
				next_st.status[S_COI]    = 1'b0;
				next_st.status[S_TRC]    = 1'b0;
				next_st.status[S_ACKD]   = 1'b0;
				next_st.status[S_STD]    = 1'b0;
			end
			// data path events set flags; a set wins over an exit or stop clear
			if (master_set)         next_st.status[S_MASTER] = 1'b1;
			if (extension_code_set) next_st.status[S_EXC]    = 1'b1;
			if (address_match_set)  next_st.status[S_COI]    = 1'b1;
			if (transmit_dir_set)   next_st.status[S_TRC]    = 1'b1;
			if (ack_detected_set)   next_st.status[S_ACKD]   = 1'b1;
			if (start_fail_set)     next_st.start_fail       = 1'b1;
			// standby ends on match or extension code after a start
			if (st.phase == PH_STANDBY && !exit_cmd && st.status[S_STD]
			    && (address_match_set || extension_code_set))
				next_st.phase = PH_XFER;
		end else if (next_st.enable) begin
			// enable rising; a low data line under the filter looks like a start
			next_st.phase = PH_IDLE;
			next_st.cld   = scl_s;
			next_st.dad   = sda_s;
			if (digital_filter_on && scl_s && !sda_s) begin
				next_st.status[S_STD] = 1'b1;
				next_st.busy = 1'b1;
			end
		end
		// disabled: status, flags, detect bits and counters held at reset, both lines released
		if (!next_st.enable) begin
			next_st.phase      = PH_OFF;
			next_st.status     = 8'h00;
			next_st.start_fail = 1'b0;
			next_st.busy       = 1'b0;
			next_st.cld        = 1'b0;
			next_st.dad        = 1'b0;
			next_st.bit_cnt    = 4'h0;
			next_st.wait_ninth = 1'b0;
			next_st.scl_oe     = 1'b0;
			next_st.sda_oe     = 1'b0;
			next_st.irq        = 1'b0;
		end
	end

	// state register; reset gives a zero control byte
	always_ff @(posedge clock) begin
		if (srst) begin
			st <= '0;
			st.phase <= PH_OFF;
			st.scl_q <= 1'b1;
			st.sda_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// every output but the constant-low scl_out and sda_out is a flop of the state
	assign reg_rdata     = st.rdata;
	assign scl_out       = 1'b0;
	assign sda_out       = 1'b0;
	assign scl_oe        = st.scl_oe;
	assign sda_oe        = st.sda_oe;
	assign irq           = st.irq;
	assign start_trigger = st.stt;
	assign stop_trigger  = st.spt;
	assign status_reg    = st.status;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// named steps of the exit and cancel sequences
	// an exit written together with a disable parks in the off phase instead
	sequence s_exit_write;
		exit_cmd && wr_val[B_ENABLE];
	endsequence

	sequence s_cancel_write;
		wrel_cmd && st.phase == PH_WAIT;
	endsequence

	a_reset_clears: assert property ($fell(srst) |-> ctl_view(st) == CTL_RESET)
		else $error("control register not zero after reset");
	a_cmd_reads_zero: assert property ((reg_rd && ctl_hit) |=> reg_rdata[6:5] == 2'b00)
		else $error("command bits read back nonzero");
	a_off_holds_idle: assert property (!st.enable |-> (st.status == 8'h00 && !st.busy && !st.scl_oe))
		else $error("disabled slice not idle");
	a_exit_standby: assert property (s_exit_write |=> (st.phase == PH_STANDBY && !st.stt && !st.scl_oe))
		else $error("exit command did not release and park");
	a_exit_flags: assert property ((s_exit_write and !address_match_set) |=> !st.status[S_COI] && !st.status[S_STD])
		else $error("exit command left flags set");
	a_cmd_ignored: assert property ((wr_any && !st.enable) |=> st.phase != PH_STANDBY)
		else $error("command honoured while disabled");
	a_cancel_frees: assert property (s_cancel_write |=> (!st.scl_oe && st.phase == PH_XFER))
		else $error("wait cancel did not release clock");
	a_wait_holds: assert property (st.phase == PH_WAIT |-> st.scl_oe)
		else $error("wait without clock held low");
	a_stop_irq: assert property ((stop_ev && st.spie) |=> irq)
		else $error("stop interrupt missing");
	a_false_start: assert property ((!st.enable && wr_any && wr_mask[B_ENABLE] && wr_val[B_ENABLE]
		&& digital_filter_on && scl_s && !sda_s) |=> st.status[S_STD])
		else $error("enable with low data did not flag start");
	a_off_clears: assert property ($fell(st.enable) |-> !st.start_fail && !st.cld && !st.dad)
		else $error("disable left detect bits set");
endmodule

// >>> i2c_ctl_pkg.sv
// Purpose: shared constants for the two-wire controller control slice
// Assumes: 16-bit register address, 8-bit register data
// Notes:   status and flag layouts below are local to this slice
package i2c_ctl_pkg;

	// register addresses
	localparam logic [15:0] ADDR_CTL_MAIN  = 16'hFFA6; // i2c_control_main
	localparam logic [15:0] ADDR_CLK_SEL   = 16'hFFA8; // level detect view
	localparam logic [15:0] ADDR_STATUS    = 16'hFFAA; // status_reg view
	localparam logic [15:0] ADDR_FLAGS     = 16'hFFAB; // start fail and busy view

	// control register bit positions
	localparam int B_ENABLE = 7; // op_enable
	localparam int B_EXIT   = 6; // exit_comm_cmd
	localparam int B_WREL   = 5; // wait_cancel_cmd
	localparam int B_SPIE   = 4; // stop_irq_enable
	localparam int B_WTIM   = 3; // wait_timing_sel
	localparam int B_ACKE   = 2; // ack_enable
	localparam int B_STT    = 1; // start_trigger
	localparam int B_SPT    = 0; // stop_trigger

	// status register bit positions
	localparam int S_MASTER = 7; // master_status
	localparam int S_EXC    = 5; // extension_code_flag
	localparam int S_COI    = 4; // address_match_flag
	localparam int S_TRC    = 3; // transmit_dir_flag
	localparam int S_ACKD   = 2; // ack_detected_flag
	localparam int S_STD    = 1; // start_detected_flag
	localparam int S_SPD    = 0; // stop detected

	// flag and clock select view positions
	localparam int F_FAIL = 7; // start_fail_flag
	localparam int F_BUSY = 6; // bus_busy_flag
	localparam int C_CLD  = 5; // clock_level_detect
	localparam int C_DAD  = 4; // data_level_detect

	localparam logic [7:0] CTL_RESET = 8'h00; // control register reset value
	localparam logic [3:0] WAIT_EARLY = 4'h8;  // eighth falling edge
	localparam logic [3:0] WAIT_LATE  = 4'h9;  // ninth falling edge

	// link phase of the control slice
	typedef enum logic [2:0] {
		PH_OFF,
		PH_IDLE,
		PH_XFER,
		PH_WAIT,
		PH_STANDBY
	} phase_t;

endpackage

// >>> line_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for pin levels
// Assumes: pins idle high, so every stage resets to one
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module line_sync3 #(
	parameter int WIDTH = 2 // number of lines
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	// stage one is read by stage two only, to keep metastability contained
	logic [WIDTH-1:0] ff1;
	logic [WIDTH-1:0] ff2;
	logic [WIDTH-1:0] ff3;

	initial begin
		if (WIDTH < 1) $error("line_sync3: WIDTH must be at least 1");
	end

	// shift chain and filtered output
	always_ff @(posedge clock) begin
		if (srst) begin
			ff1  <= '1;
			ff2  <= '1;
			ff3  <= '1;
			dout <= '1;
		end else begin
			ff1 <= din;
			ff2 <= ff1;
			ff3 <= ff2;
			for (int i = 0; i < WIDTH; i++) begin
				if (ff2[i] == ff3[i]) dout[i] <= ff3[i];
			end
		end
	end
endmodule

// >>> i2c_bus_peer.sv
// Purpose: behavioural peer master standing on the shared two-wire bus
// Assumes: pull-ups on both lines; the slice drives output enables only
// Notes:   a released line reads high through its pull-up, never a stale value
`timescale 1ns/1ps
module i2c_bus_peer (
	input  wire logic scl_oe,   // slice pulls the clock line low
	input  wire logic sda_oe,   // slice pulls the data line low
	output logic      scl_line, // wired level of the clock line
	output logic      sda_line  // wired level of the data line
);
	localparam int HALF = 200; // half of the 400 ns link period

	logic scl_drv = 1'h1; // peer clock drive, one releases
	logic sda_drv = 1'h1; // peer data drive, one releases

	// wired-and of every party; the clock stands high outside frames
	assign scl_line = scl_drv & ~scl_oe;
	assign sda_line = sda_drv & ~sda_oe;

	// data falls with clock high; the following clock fall only ends the start
	task automatic start_cond();
		sda_drv = 1'h0;
		#HALF scl_drv = 1'h0;
		#HALF;
	endtask

	// n clocks; a held-low clock is waited for, but only for a bounded time
	task automatic clocks(input int n);
		repeat (n) begin
			scl_drv = 1'h1;
			for (int i = 0; i < 100 && scl_line !== 1'h1; i++) #10;
			#HALF scl_drv = 1'h0;
			#HALF;
		end
	endtask

	// data rises with clock high
	task automatic stop_cond();
		sda_drv = 1'h0;
		#HALF scl_drv = 1'h1;
		#HALF sda_drv = 1'h1;
		#HALF;
	endtask

	// set the data drive directly, used to hold data low while idle
	task automatic data_drive(input logic v);
		sda_drv = v;
	endtask
endmodule

// >>> i2c_control_enable_wait_bench.sv
// Purpose: self-checking bench for the control slice of the two-wire controller
// Assumes: 50 ns system clock, peer model on the bus lines
// Notes:   waits after pin moves are fixed at ten cycles to cover the synchroniser
`timescale 1ns/1ps
module i2c_control_enable_wait_bench;
	import i2c_ctl_pkg::*;

	logic        clock = 1'h0;        // system clock
	logic        srst = 1'h1;         // synchronous reset
	logic [15:0] reg_addr = 16'h0000; // register address
	logic [7:0]  reg_wdata = 8'h00;   // register write data
	logic        reg_wr = 1'h0;       // byte write strobe
	logic        reg_bit_wr = 1'h0;   // single-bit write strobe
	logic [2:0]  reg_bit_idx = 3'h0;  // bit number for bit writes
	logic        reg_rd = 1'h0;       // read strobe
	logic        filter_on = 1'h0;    // digital filter setting
	logic [5:0]  set_pulse = 6'h00;   // master, ext, match, tx, ack, fail
	logic        master_set, ext_set, match_set; // set pulses, one per flag
	logic        tx_set, ack_set, fail_set;
	logic        scl_pin, sda_pin;    // open-drain drive values, always low
	logic [7:0]  reg_rdata;           // read data
	logic [7:0]  status_reg;          // status view
	logic        scl_line, sda_line;  // wired bus levels
	logic        scl_oe, sda_oe;      // slice pull-downs
	logic        irq, start_trigger, stop_trigger;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          irq_count = 0;       // interrupt pulses seen
	int          n;                   // irq count snapshot

	assign {master_set, ext_set, match_set, tx_set, ack_set, fail_set} = set_pulse;

	i2c_control_enable_wait u_dut (
		.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_bit_wr(reg_bit_wr), .reg_bit_idx(reg_bit_idx),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_line(scl_line),
		.serial_data_line(sda_line), .scl_out(scl_pin), .scl_oe(scl_oe), .sda_out(sda_pin),
		.sda_oe(sda_oe), .digital_filter_on(filter_on), .master_set(master_set),
		.extension_code_set(ext_set), .address_match_set(match_set),
		.transmit_dir_set(tx_set), .ack_detected_set(ack_set),
		.start_fail_set(fail_set), .irq(irq), .start_trigger(start_trigger),
		.stop_trigger(stop_trigger), .status_reg(status_reg)
	);

	i2c_bus_peer u_peer (
		.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line)
	);

	// clock and interrupt pulse counter
	always #25 clock = ~clock;
	always @(posedge clock) if (irq === 1'h1) irq_count <= irq_count + 1;

	task automatic compare(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic compare_bit(input logic got, input logic exp);
		compare({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask
	task automatic bwr(input logic [2:0] idx, input logic v);
		@(posedge clock);
		reg_addr <= ADDR_CTL_MAIN;
		reg_bit_idx <= idx;
		reg_wdata <= {7'h00, v};
		reg_bit_wr <= 1'h1;
		@(posedge clock);
		reg_bit_wr <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		@(negedge clock);
		compare(reg_rdata, exp);
	endtask
	task automatic pulse(input logic [5:0] p);
		@(posedge clock);
		set_pulse <= p;
		@(posedge clock);
		set_pulse <= 6'h00;
	endtask
	// lets pin moves pass the synchroniser before outputs are sampled
	task automatic settle();
		repeat (10) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic t_reset();
		rd_check(ADDR_CTL_MAIN, CTL_RESET);
		rd_check(ADDR_STATUS, 8'h00);
		rd_check(16'h1234, 8'h00);
		compare({2'h0, scl_pin, sda_pin, start_trigger, stop_trigger, scl_oe, sda_oe}, 8'h00);
	endtask
	// option bits taken at enable rise and while off, rewritten unchanged with enable held; lines stand high
	task automatic t_access();
		wr(ADDR_CTL_MAIN, 8'hFC);
		rd_check(ADDR_CTL_MAIN, 8'h9C);
		wr(ADDR_CTL_MAIN, 8'hDC);
		rd_check(ADDR_CTL_MAIN, 8'h9C);
		bwr(B_ENABLE, 1'h0);
		rd_check(ADDR_CTL_MAIN, 8'h1C);
		rd_check(ADDR_FLAGS, 8'h00);
		bwr(B_WTIM, 1'h0);
		bwr(B_ENABLE, 1'h1);
		rd_check(ADDR_CTL_MAIN, 8'h94);
	endtask
	task automatic t_wait8();
		u_peer.start_cond();
		n = irq_count;
		u_peer.clocks(7);
		settle();
		compare_bit(scl_oe, 1'h0);
		u_peer.clocks(1);
		settle();
		compare({6'h00, scl_oe, sda_oe}, 8'h03);
		compare(8'(irq_count - n), 8'h01);
		bwr(B_WREL, 1'h1);
		settle();
		compare_bit(scl_oe, 1'h0);
		rd_check(ADDR_CTL_MAIN, 8'h94);
		u_peer.clocks(1);
		settle();
		compare_bit(sda_oe, 1'h0);
		n = irq_count;
		u_peer.stop_cond();
		settle();
		compare(8'(irq_count - n), 8'h01);
	endtask
	task automatic t_wait9();
		wr(ADDR_CTL_MAIN, 8'h00);
		wr(ADDR_CTL_MAIN, 8'h88);
		u_peer.start_cond();
		pulse(6'h04);
		u_peer.clocks(8);
		settle();
		compare_bit(scl_oe, 1'h0);
		u_peer.clocks(1);
		settle();
		compare({6'h00, scl_oe, status_reg[S_TRC]}, 8'h03);
		bwr(B_WREL, 1'h1);
		settle();
		compare({6'h00, scl_oe, status_reg[S_TRC]}, 8'h00);
		pulse(6'h22);
		bwr(B_STT, 1'h1);
		bwr(B_SPT, 1'h1);
		settle();
		compare((status_reg & 8'h84) | {6'h00, start_trigger, stop_trigger}, 8'h87);
		bwr(B_EXIT, 1'h1);
		settle();
		compare(status_reg, 8'h00);
		compare({4'h0, start_trigger, stop_trigger, scl_oe, sda_oe}, 8'h00);
		u_peer.clocks(9);
		settle();
		compare_bit(scl_oe, 1'h0);
		n = irq_count;
		u_peer.stop_cond();
		settle();
		compare(8'(irq_count - n), 8'h00);
	endtask
	// enabling with data held low and the filter on sees a start at once
	task automatic t_false_start();
		wr(ADDR_CTL_MAIN, 8'h00);
		@(posedge clock);
		filter_on <= 1'h1;
		u_peer.data_drive(1'h0);
		settle();
		wr(ADDR_CTL_MAIN, 8'h80);
		settle();
		compare_bit(status_reg[S_STD], 1'h1);
		rd_check(ADDR_FLAGS, 8'h40);
		bwr(B_EXIT, 1'h1);
		settle();
		compare(status_reg, 8'h00);
		// flags without a start do not end standby; fail and busy stay up
		pulse(6'h19);
		settle();
		compare(status_reg, 8'h30);
		rd_check(ADDR_FLAGS, 8'hC0);
		rd_check(ADDR_CLK_SEL, 8'h20);
		wr(ADDR_CTL_MAIN, 8'h00);
		settle();
		compare(status_reg, 8'h00);
		rd_check(ADDR_FLAGS, 8'h00);
		rd_check(ADDR_CLK_SEL, 8'h00);
		u_peer.data_drive(1'h1);
		settle();
		compare(status_reg, 8'h00);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'h0;
		t_reset();
		t_access();
		t_wait8();
		t_wait9();
		// second reset in mid-run, slice enabled and lines idle
		@(posedge clock);
		srst <= 1'h1;
		repeat (4) @(posedge clock);
		srst <= 1'h0;
		t_reset();
		t_false_start();
		stop_test();
	end
	// watchdog, well beyond the expected run of about 26 us
	initial begin
		#2000000;
		miscompares++;
		stop_test();
	end
endmodule
